/* common/lin_pos_pkg.sv */
// Shared constants and helpers for the LIN read-position command
package lin_pos_pkg;

	// ==========================================
	// Frame identifiers and fixed bytes
	localparam logic [7:0] ID_FIXED_PREP = 8'h3C;
	localparam logic [7:0] ID_FIXED_READ = 8'h7D;
	localparam logic [7:0] APP_CMD = 8'h80;
	localparam logic [7:0] FILLER = 8'hFF;
	localparam logic [6:0] CMD_READ_POS = 7'h00;
	localparam logic CMD_FLAG = 1'b1;
	localparam logic ADDR_FLAG = 1'b1;
	localparam logic EXT_CONST = 1'b1;
	localparam logic [1:0] PARITY_PAD = 2'h0;

	// ==========================================
	// Identifier field layout
	localparam int LEN_HI = 5;
	localparam int LEN_LO = 4;
	localparam int PREP_SEL_BIT = 5;
	localparam logic [1:0] DIRECT_LEN = 2'h2;
	localparam logic PREP_SEL_SHORT = 1'b0;

	// ==========================================
	// Byte indices and frame lengths
	localparam logic [3:0] FIRST_DATA = 4'h1;
	localparam logic [3:0] BYTE_ADDR = 4'h1;
	localparam logic [3:0] BYTE_POS_HI = 4'h2;
	localparam logic [3:0] BYTE_POS_LO = 4'h3;
	localparam logic [3:0] BYTE_STATUS = 4'h4;
	localparam logic [3:0] BYTE_EXT = 4'h5;
	localparam logic [3:0] DIRECT_BYTES = 4'h4;
	localparam logic [3:0] INDIRECT_BYTES = 4'h8;
	localparam logic [3:0] SHORT_PREP_LAST = 4'h2;
	localparam logic [3:0] LONG_PREP_LAST = 4'h8;
	localparam logic [3:0] LONG_PREP_SHIFT = 4'h1;

	// ==========================================
	// Master wait for an answer
	localparam logic [4:0] RESP_WAIT_CYCLES = 5'h10;

	typedef enum logic [1:0]
	{
		READ_DIRECT = 2'b00,
		READ_SHORT_PREP = 2'b01,
		READ_LONG_PREP = 2'b10
	} read_mode_t;

	// ==========================================
	// Preparing frame data byte at a given index
	function automatic logic [7:0] prep_byte(input logic long_form, input logic [3:0] idx,
		input logic [6:0] addr);
		logic [3:0] k;
		k = long_form ? idx - LONG_PREP_SHIFT : idx;
		if (long_form && idx == FIRST_DATA)
			prep_byte = APP_CMD;
		else if (k == FIRST_DATA)
			prep_byte = {CMD_FLAG, CMD_READ_POS};
		else if (k == SHORT_PREP_LAST)
			prep_byte = {ADDR_FLAG, addr};
		else
			prep_byte = FILLER;
	endfunction : prep_byte

endpackage : lin_pos_pkg

/* common/lin_link_if.sv */
// Byte-level LIN link between master and slave
`timescale 1ns/1ps
interface lin_link_if;
	logic m_id;
	logic m_valid;
	logic [7:0] m_data;
	logic s_valid;
	logic [7:0] s_data;

	modport master
	(
		output m_id,
		output m_valid,
		output m_data,
		input s_valid,
		input s_data
	);

	modport slave
	(
		input m_id,
		input m_valid,
		input m_data,
		output s_valid,
		output s_data
	);
endinterface : lin_link_if

/* src/lin_pos_resp_byte.sv */
// Response byte selector for the read-position answer
`timescale 1ns/1ps
module lin_pos_resp_byte
(
	// Byte index
	input wire logic [3:0] idx_i,
	// Answer content
	input wire logic end_switch_state_i,
	input wire logic [6:0] node_addr_i,
	input wire logic [15:0] actual_position_i,
	input wire logic [7:0] status_i,
	input wire logic [3:0] device_code_i,
	input wire logic [2:0] ext_flags_i,
	// Selected byte
	output logic [7:0] byte_o
);
	// ==========================================
	// Byte mux
	always_comb
	begin
		unique case (idx_i)
			lin_pos_pkg::BYTE_ADDR: byte_o = {end_switch_state_i, node_addr_i};
			lin_pos_pkg::BYTE_POS_HI: byte_o = actual_position_i[15:8];
			lin_pos_pkg::BYTE_POS_LO: byte_o = actual_position_i[7:0];
			lin_pos_pkg::BYTE_STATUS: byte_o = status_i;
			lin_pos_pkg::BYTE_EXT: byte_o = {device_code_i, lin_pos_pkg::EXT_CONST, ext_flags_i};
			default: byte_o = lin_pos_pkg::FILLER;
		endcase
	end
endmodule : lin_pos_resp_byte

/* src/lin_pos_slave.sv */
// LIN slave end answering the read-position command
// What this block does
// - Position signed sixteen bits, high byte first
// - Master zeroes meaningless low position bits
// - Answer carries short status byte too
// - Reading position clears no flag
// - Direct read returns four fixed data bytes
// - Direct identifier length bits are 10
// - Master gives each node own direct identifier
// - Master prepares, then fixed-identifier read frame
// - Short prepare: command 00, node address
// - Long prepare: 3C, 80, command, address, fillers
// - Indirect answer: eight bytes under 7D
// - Master sends identifiers, slave answers data
`timescale 1ns/1ps
module lin_pos_slave
#(
	// Arbitrary device code value
	parameter logic [3:0] DEVICE_CODE = 4'h5
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// Link to master
	lin_link_if.slave link,
	// Node identity
	input wire logic [6:0] node_addr_i,
	input wire logic [3:0] direct_id_i,
	input wire logic [4:0] prep_id_i,
	// Motor state
	input wire logic [15:0] actual_position_i,
	input wire logic end_switch_state_i,
	// Latched flags
	input wire logic logic_supply_reset_flag_i,
	input wire logic step_loss_flag_i,
	input wire logic electrical_defect_flag_i,
	input wire logic undervoltage_flag_i,
	input wire logic thermal_shutdown_flag_i,
	input wire logic thermal_warning_flag_i,
	input wire logic [1:0] temperature_info_i,
	input wire logic second_undervoltage_flag_i,
	input wire logic third_undervoltage_flag_i,
	input wire logic bus_error_flag_i,
	// Activity
	output logic answering_o,
	output logic read_pending_o
);
	// ==========================================
	// State and storage
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_PREP_SHORT = 2'b01,
		ST_PREP_LONG = 2'b10,
		ST_ANSWER = 2'b11
	} slave_state_t;

	slave_state_t state_q;
	logic [3:0] idx_q;
	logic [3:0] len_q;
	logic match_q;
	logic pending_q;
	logic [15:0] pos_q;
	logic esw_q;
	logic [7:0] status_q;
	logic [2:0] ext_q;
	logic s_valid_q;
	logic [7:0] s_data_q;
	logic [7:0] resp_byte;

	// ==========================================
	// Identifier decode
	logic id_direct;
	logic id_short;
	logic id_long;
	logic id_read;
	logic in_prep;
	logic prep_last;
	logic byte_ok;
	logic answer_last;

	assign id_direct = link.m_id
		&& link.m_data[lin_pos_pkg::LEN_HI:lin_pos_pkg::LEN_LO] == lin_pos_pkg::DIRECT_LEN
		&& link.m_data[3:0] == direct_id_i;
	assign id_short = link.m_id
		&& link.m_data[lin_pos_pkg::PREP_SEL_BIT] == lin_pos_pkg::PREP_SEL_SHORT
		&& link.m_data[4:0] == prep_id_i;
	assign id_long = link.m_id && link.m_data == lin_pos_pkg::ID_FIXED_PREP;
	assign id_read = link.m_id && link.m_data == lin_pos_pkg::ID_FIXED_READ;

	assign in_prep = state_q == ST_PREP_SHORT || state_q == ST_PREP_LONG;
	assign prep_last = idx_q == ((state_q == ST_PREP_LONG) ? lin_pos_pkg::LONG_PREP_LAST
		: lin_pos_pkg::SHORT_PREP_LAST);
	assign byte_ok = link.m_data == lin_pos_pkg::prep_byte(state_q == ST_PREP_LONG, idx_q,
		node_addr_i);
	assign answer_last = idx_q == len_q;

	// ==========================================
	// Frame sequencer
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			state_q <= ST_IDLE;
			idx_q <= lin_pos_pkg::FIRST_DATA;
			len_q <= lin_pos_pkg::DIRECT_BYTES;
		end
		else if (link.m_id)
		begin
			idx_q <= lin_pos_pkg::FIRST_DATA;
			if (id_direct)
			begin
				state_q <= ST_ANSWER;
				len_q <= lin_pos_pkg::DIRECT_BYTES;
			end
			else if (id_read && pending_q)
			begin
				state_q <= ST_ANSWER;
				len_q <= lin_pos_pkg::INDIRECT_BYTES;
			end
			else if (id_short)
				state_q <= ST_PREP_SHORT;
			else if (id_long)
				state_q <= ST_PREP_LONG;
			else
				state_q <= ST_IDLE;
		end
		else
		begin
			unique case (state_q)
				ST_IDLE: state_q <= ST_IDLE;
				ST_PREP_SHORT, ST_PREP_LONG:
				begin
					if (link.m_valid)
					begin
						if (prep_last)
							state_q <= ST_IDLE;
						else
							idx_q <= idx_q + lin_pos_pkg::FIRST_DATA;
					end
				end
				ST_ANSWER:
				begin
					if (answer_last)
						state_q <= ST_IDLE;
					else
						idx_q <= idx_q + lin_pos_pkg::FIRST_DATA;
				end
			endcase
		end
	end

	// ==========================================
	// Preparing frame check
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			match_q <= 1'b0;
		else if (link.m_id)
			match_q <= 1'b1;
		else if (in_prep && link.m_valid)
			match_q <= match_q && byte_ok;
	end

	// ==========================================
	// Prepared read pending
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			pending_q <= 1'b0;
		else if (link.m_id)
			pending_q <= 1'b0;
		else if (in_prep && link.m_valid && prep_last)
			pending_q <= match_q && byte_ok;
	end

	// ==========================================
	// Answer snapshot
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			pos_q <= 16'h0000;
			esw_q <= 1'b0;
			status_q <= 8'h00;
			ext_q <= 3'h0;
		end
		else if (link.m_id)
		begin
			pos_q <= actual_position_i;
			esw_q <= end_switch_state_i;
			status_q <= {logic_supply_reset_flag_i, step_loss_flag_i, electrical_defect_flag_i,
				undervoltage_flag_i, thermal_shutdown_flag_i, thermal_warning_flag_i,
				temperature_info_i};
			ext_q <= {second_undervoltage_flag_i, third_undervoltage_flag_i, bus_error_flag_i};
		end
	end

	lin_pos_resp_byte u_lin_pos_resp_byte
	(
		.idx_i(idx_q),
		.end_switch_state_i(esw_q),
		.node_addr_i(node_addr_i),
		.actual_position_i(pos_q),
		.status_i(status_q),
		.device_code_i(DEVICE_CODE),
		.ext_flags_i(ext_q),
		.byte_o(resp_byte)
	);

	// ==========================================
	// Answer output
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			s_valid_q <= 1'b0;
			s_data_q <= 8'h00;
		end
		else
		begin
			s_valid_q <= state_q == ST_ANSWER && !link.m_id;
			s_data_q <= (state_q == ST_ANSWER && !link.m_id) ? resp_byte : 8'h00;
		end
	end

	// Flags are only sampled, never cleared
	assign link.s_valid = s_valid_q;
	assign link.s_data = s_data_q;
	assign answering_o = state_q == ST_ANSWER;
	assign read_pending_o = pending_q;

endmodule : lin_pos_slave

/* src/lin_pos_master.sv */
// LIN master end issuing the read-position command
`timescale 1ns/1ps
module lin_pos_master
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// Link to slave
	lin_link_if.master link,
	// Request
	input wire logic req_i,
	input wire lin_pos_pkg::read_mode_t mode_i,
	input wire logic [3:0] direct_id_i,
	input wire logic [4:0] prep_id_i,
	input wire logic [6:0] node_addr_i,
	input wire logic [3:0] zero_bits_i,
	// Result
	output logic busy_o,
	output logic done_o,
	output logic no_answer_o,
	output logic [15:0] position_o,
	output logic end_switch_state_o,
	output logic [6:0] answer_addr_o,
	output logic [7:0] status_o,
	output logic [7:0] ext_status_o
);
	// ==========================================
	// State and storage
	typedef enum logic [2:0]
	{
		H_IDLE = 3'b000,
		H_PREP_ID = 3'b001,
		H_PREP_DATA = 3'b010,
		H_READ_ID = 3'b011,
		H_COLLECT = 3'b100
	} master_state_t;

	master_state_t state_q;
	lin_pos_pkg::read_mode_t mode_q;
	logic [3:0] did_q;
	logic [4:0] pid_q;
	logic [6:0] addr_q;
	logic [3:0] zero_q;
	logic [3:0] idx_q;
	logic [4:0] wait_q;
	logic m_id_q;
	logic m_valid_q;
	logic [7:0] m_data_q;
	logic done_q;
	logic miss_q;
	logic [7:0] rx_q [1:8];
	logic long_form;
	logic [3:0] rx_len;
	logic [15:0] keep_mask;

	assign long_form = mode_q == lin_pos_pkg::READ_LONG_PREP;
	assign rx_len = (mode_q == lin_pos_pkg::READ_DIRECT) ? lin_pos_pkg::DIRECT_BYTES
		: lin_pos_pkg::INDIRECT_BYTES;

	// ==========================================
	// Frame sequencer
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			state_q <= H_IDLE;
			mode_q <= lin_pos_pkg::READ_DIRECT;
			did_q <= 4'h0;
			pid_q <= 5'h00;
			addr_q <= 7'h00;
			zero_q <= 4'h0;
			idx_q <= lin_pos_pkg::FIRST_DATA;
			wait_q <= 5'h00;
			m_id_q <= 1'b0;
			m_valid_q <= 1'b0;
			m_data_q <= 8'h00;
			done_q <= 1'b0;
			miss_q <= 1'b0;
		end
		else
		begin
			m_id_q <= 1'b0;
			m_valid_q <= 1'b0;
			done_q <= 1'b0;
			miss_q <= 1'b0;
			unique case (state_q)
				H_IDLE:
				begin
					if (req_i)
					begin
						mode_q <= mode_i;
						did_q <= direct_id_i;
						pid_q <= prep_id_i;
						addr_q <= node_addr_i;
						zero_q <= zero_bits_i;
						// Indirect reads start with a prepare
						state_q <= (mode_i == lin_pos_pkg::READ_DIRECT) ? H_READ_ID : H_PREP_ID;
					end
				end
				H_PREP_ID:
				begin
					m_id_q <= 1'b1;
					m_data_q <= long_form ? lin_pos_pkg::ID_FIXED_PREP
						: {lin_pos_pkg::PARITY_PAD, lin_pos_pkg::PREP_SEL_SHORT, pid_q};
					idx_q <= lin_pos_pkg::FIRST_DATA;
					state_q <= H_PREP_DATA;
				end
				H_PREP_DATA:
				begin
					m_valid_q <= 1'b1;
					m_data_q <= lin_pos_pkg::prep_byte(long_form, idx_q, addr_q);
					if (idx_q == (long_form ? lin_pos_pkg::LONG_PREP_LAST
						: lin_pos_pkg::SHORT_PREP_LAST))
						state_q <= H_READ_ID;
					else
						idx_q <= idx_q + lin_pos_pkg::FIRST_DATA;
				end
				H_READ_ID:
				begin
					m_id_q <= 1'b1;
					m_data_q <= (mode_q == lin_pos_pkg::READ_DIRECT)
						? {lin_pos_pkg::PARITY_PAD, lin_pos_pkg::DIRECT_LEN, did_q}
						: lin_pos_pkg::ID_FIXED_READ;
					idx_q <= lin_pos_pkg::FIRST_DATA;
					wait_q <= 5'h00;
					state_q <= H_COLLECT;
				end
				H_COLLECT:
				begin
					if (link.s_valid)
					begin
						wait_q <= 5'h00;
						if (idx_q == rx_len)
						begin
							done_q <= 1'b1;
							state_q <= H_IDLE;
						end
						else
							idx_q <= idx_q + lin_pos_pkg::FIRST_DATA;
					end
					else if (wait_q == lin_pos_pkg::RESP_WAIT_CYCLES)
					begin
						miss_q <= 1'b1;
						state_q <= H_IDLE;
					end
					else
						wait_q <= wait_q + 5'h01;
				end
				default: state_q <= H_IDLE;
			endcase
		end
	end

	// ==========================================
	// Answer capture
	always_ff @(posedge clk_i)
	begin
		if (srst_i || (state_q == H_IDLE && req_i))
		begin
			for (int i = 1; i <= 8; i++)
				rx_q[i] <= 8'h00;
		end
		else if (state_q == H_COLLECT && link.s_valid)
			rx_q[idx_q] <= link.s_data;
	end

	// Meaningless low bits read as zero
	assign keep_mask = 16'hFFFF << zero_q;
	assign position_o = {rx_q[lin_pos_pkg::BYTE_POS_HI], rx_q[lin_pos_pkg::BYTE_POS_LO]} & keep_mask;
	assign end_switch_state_o = rx_q[lin_pos_pkg::BYTE_ADDR][7];
	assign answer_addr_o = rx_q[lin_pos_pkg::BYTE_ADDR][6:0];
	assign status_o = rx_q[lin_pos_pkg::BYTE_STATUS];
	assign ext_status_o = rx_q[lin_pos_pkg::BYTE_EXT];
	assign busy_o = state_q != H_IDLE;
	assign done_o = done_q;
	assign no_answer_o = miss_q;
	assign link.m_id = m_id_q;
	assign link.m_valid = m_valid_q;
	assign link.m_data = m_data_q;

endmodule : lin_pos_master

/* verif/lin_pos_monitor.sv */
// Concurrent checks on the read-position link
`timescale 1ns/1ps
module lin_pos_monitor
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// Link signals
	input wire logic m_id,
	input wire logic m_valid,
	input wire logic [7:0] m_data,
	input wire logic s_valid,
	input wire logic [7:0] s_data
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (srst_i);

	// ==========================================
	// Properties
	sequence s_ind;
		m_id && m_data == 8'h7D ##2 s_valid;
	endsequence
	property p_direct_len;
		m_id && m_data[5:4] == 2'b10 ##2 s_valid |-> s_valid[*4] ##1 !s_valid;
	endproperty
	property p_direct_id;
		m_id && m_data[5:4] == 2'b10 |-> m_data[7:6] == 2'b00;
	endproperty
	property p_ind_len;
		s_ind |-> s_valid[*8] ##1 !s_valid;
	endproperty
	property p_ind_fill;
		s_ind |-> ##5 (s_data == 8'hFF)[*3];
	endproperty
	property p_ext_const;
		s_ind |-> ##4 s_data[3];
	endproperty
	property p_ans_start;
		$rose(s_valid) |-> $past(m_id, 2);
	endproperty
	property p_idle_zero;
		!s_valid |-> s_data == 8'h00;
	endproperty
	property p_excl;
		m_valid |-> !s_valid;
	endproperty
	property p_long_prep;
		m_id && m_data == 8'h3C |-> ##1 m_valid && m_data == 8'h80
			##1 m_valid && m_data == 8'h80 ##1 m_valid && m_data[7]
			##1 (m_valid && m_data == 8'hFF)[*5];
	endproperty
	property p_prep_read;
		m_id && m_data == 8'h3C |-> ##9 m_id && m_data == 8'h7D;
	endproperty
	property p_short_prep;
		m_id && !m_data[5] |-> ##[1:4] (m_valid && m_data == 8'h80);
	endproperty

	// ==========================================
	// Assertions
	a_direct_len: assert property (p_direct_len)
		else $error("direct answer length wrong");
	a_direct_id: assert property (p_direct_id)
		else $error("direct identifier bits wrong");
	a_ind_len: assert property (p_ind_len)
		else $error("indirect answer length wrong");
	a_ind_fill: assert property (p_ind_fill)
		else $error("indirect filler bytes wrong");
	a_ext_const: assert property (p_ext_const)
		else $error("extended status constant bit wrong");
	a_ans_start: assert property (p_ans_start)
		else $error("answer without identifier");
	a_idle_zero: assert property (p_idle_zero)
		else $error("slave data not zero while idle");
	a_excl: assert property (p_excl)
		else $error("slave and master bytes collide");
	a_long_prep: assert property (p_long_prep)
		else $error("long prepare frame wrong");
	a_prep_read: assert property (p_prep_read)
		else $error("read frame does not follow prepare");
	a_short_prep: assert property (p_short_prep)
		else $error("short prepare command byte wrong");

	// ==========================================
	// Covers
	c_direct: cover property (m_id && m_data[5:4] == 2'b10 ##2 s_valid);
	c_ind: cover property (s_ind);
	c_short: cover property (m_id && !m_data[5]);
endmodule : lin_pos_monitor

/* verif/tb_lin_position_query_response.sv */
// Self-checking bench joining master and slave ends
`timescale 1ns/1ps
module tb_lin_position_query_response;
	// Arbitrary device code value
	localparam logic [3:0] DEV_CODE = 4'hA;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic req = 1'b0;
	lin_pos_pkg::read_mode_t mode = lin_pos_pkg::READ_DIRECT;
	logic [3:0] m_did = 4'h0;
	logic [4:0] m_pid = 5'h00;
	logic [6:0] m_addr = 7'h00;
	logic [3:0] zb = 4'h0;
	logic [3:0] s_did = 4'h0;
	logic [4:0] s_pid = 5'h00;
	logic [6:0] s_addr = 7'h00;
	logic [15:0] pos = 16'h0000;
	logic end_switch_state = 1'b0;
	logic [7:0] fl = 8'h00;
	logic [2:0] xf = 3'h0;
	logic busy, done, no_ans, esw_o, answering, pending;
	logic [15:0] pos_o;
	logic [6:0] addr_o;
	logic [7:0] st_o, ext_o;
	logic [40:0] exp_q[$];
	int err_total = 0;
	int tests_run = 0;
	logic pend_seen = 1'b0;
	logic ans_seen = 1'b0;

	always #50 clk_i = ~clk_i;

	// ==========================================
	// Ends and checker
	lin_link_if u_lin_link_if ();
	lin_pos_master u_lin_pos_master (.clk_i(clk_i), .srst_i(srst_i), .link(u_lin_link_if),
		.req_i(req), .mode_i(mode), .direct_id_i(m_did), .prep_id_i(m_pid),
		.node_addr_i(m_addr), .zero_bits_i(zb), .busy_o(busy), .done_o(done),
		.no_answer_o(no_ans), .position_o(pos_o), .end_switch_state_o(esw_o),
		.answer_addr_o(addr_o), .status_o(st_o), .ext_status_o(ext_o));
	lin_pos_slave #(.DEVICE_CODE(DEV_CODE)) u_lin_pos_slave (.clk_i(clk_i), .srst_i(srst_i),
		.link(u_lin_link_if), .node_addr_i(s_addr), .direct_id_i(s_did), .prep_id_i(s_pid),
		.actual_position_i(pos), .end_switch_state_i(end_switch_state),
		.logic_supply_reset_flag_i(fl[7]), .step_loss_flag_i(fl[6]),
		.electrical_defect_flag_i(fl[5]), .undervoltage_flag_i(fl[4]),
		.thermal_shutdown_flag_i(fl[3]), .thermal_warning_flag_i(fl[2]),
		.temperature_info_i(fl[1:0]), .second_undervoltage_flag_i(xf[2]),
		.third_undervoltage_flag_i(xf[1]), .bus_error_flag_i(xf[0]),
		.answering_o(answering), .read_pending_o(pending));
	lin_pos_monitor u_lin_pos_monitor (.clk_i(clk_i), .srst_i(srst_i),
		.m_id(u_lin_link_if.m_id), .m_valid(u_lin_link_if.m_valid),
		.m_data(u_lin_link_if.m_data), .s_valid(u_lin_link_if.s_valid),
		.s_data(u_lin_link_if.s_data));

	// ==========================================
	// Compare and close
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out

	// ==========================================
	// Result watcher
	always @(negedge clk_i)
	begin
		if (pending === 1'b1)
			pend_seen = 1'b1;
		if (answering === 1'b1)
			ans_seen = 1'b1;
		if (done === 1'b1 || no_ans === 1'b1)
		begin
			if (exp_q.size() == 0)
				check("spare result", 16'h0001, 16'h0000);
			else
			begin
				check("no answer", 16'(no_ans), 16'(exp_q[0][40]));
				check("position", pos_o, exp_q[0][39:24]);
				check("addr byte", 16'({esw_o, addr_o}), 16'(exp_q[0][23:16]));
				check("status", 16'(st_o), 16'(exp_q[0][15:8]));
				check("ext status", 16'(ext_o), 16'(exp_q[0][7:0]));
				check("busy at result", 16'(busy), 16'h0000);
				check("answer seen", 16'(ans_seen), 16'(!exp_q[0][40]));
				check("pending seen", 16'(pend_seen), 16'(exp_q[0][3]));
				void'(exp_q.pop_front());
			end
			pend_seen = 1'b0;
			ans_seen = 1'b0;
		end
	end

	// ==========================================
	// Driver
	task automatic run(input int kind, input bit bad);
		logic [40:0] e;
		int n;
		@(posedge clk_i);
		#1;
		mode = lin_pos_pkg::read_mode_t'(kind);
		pos = 16'($urandom());
		end_switch_state = 1'($urandom());
		fl = 8'($urandom());
		xf = 3'($urandom());
		zb = 4'($urandom_range(0, 15));
		s_addr = 7'($urandom());
		s_did = 4'($urandom());
		s_pid = 5'($urandom());
		m_addr = bad ? ~s_addr : s_addr;
		m_did = bad ? ~s_did : s_did;
		m_pid = bad ? ~s_pid : s_pid;
		e = {1'b0, pos & (16'hFFFF << zb), end_switch_state, s_addr, fl,
			(kind == 0) ? 8'h00 : {DEV_CODE, 1'b1, xf}};
		if (bad)
			e = {1'b1, 40'h00_0000_0000};
		exp_q.push_back(e);
		req = 1'b1;
		@(posedge clk_i);
		#1;
		req = 1'b0;
		check("busy after take", 16'(busy), 16'h0001);
		n = 0;
		while (done !== 1'b1 && no_ans !== 1'b1 && n < 80)
		begin
			@(posedge clk_i);
			#1;
			n++;
		end
		if (n == 80)
		begin
			err_total++;
			close_out();
		end
	endtask : run

	initial
	begin
		void'($urandom(32'h0000_53B4));
		repeat (5) @(posedge clk_i);
		#1;
		srst_i = 1'b0;
		for (int i = 0; i < 24; i++)
			run(i % 3, (i % 4) == 3);
		repeat (3) @(posedge clk_i);
		check("left notes", 16'(exp_q.size()), 16'h0000);
		close_out();
	end
endmodule : tb_lin_position_query_response
